/* scsd_clock_select.sv */
// clock source select, power-of-two divider and wishbone register slave
`timescale 1ns/10ps
module scsd_clock_select
  import scsd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire scsd_wb_req_t wbReq,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire logic [SCSD_NUM_SRC-1:0] srcClockIn,
  input wire logic extOscCmosMode,
  input wire logic extOscDetectRaw,
  output logic coreClock,
  output logic extOscValidFlag
);

  // ************************************************************
  // helpers
  // ************************************************************
  // last count of one divided period, in source rising edges
  function automatic logic [6:0] lastCount(input logic [2:0] d);
    logic [7:0] n;
    n = 8'h01 << d;
    return 7'(n - 8'h01);
  endfunction

  // source edges spent high in one divided period
  function automatic logic [6:0] halfCount(input logic [2:0] d);
    logic [7:0] n;
    n = 8'h01 << d;
    return 7'(n >> 1);
  endfunction

  // ************************************************************
  // synchronisers
  // ************************************************************
  logic [SCSD_NUM_SRC-1:0] srcMeta;
  logic [SCSD_NUM_SRC-1:0] srcSync;
  logic [SCSD_NUM_SRC-1:0] srcPrev;
  logic detMeta;
  logic detSync;

  // oscillators are asynchronous to clk, so each passes two flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      srcMeta <= '0;
      srcSync <= '0;
      srcPrev <= '0;
    end else begin
      srcMeta <= srcClockIn;
      srcSync <= srcMeta;
      srcPrev <= srcSync;
    end
  end

  // valid detector is analog-side, same treatment
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      detMeta <= 1'b0;
      detSync <= 1'b0;
    end else begin
      detMeta <= extOscDetectRaw;
      detSync <= detMeta;
    end
  end

  // cmos mode has no amplitude to detect
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      extOscValidFlag <= 1'b0;
    end else begin
      extOscValidFlag <= extOscCmosMode ? 1'b0 : detSync; // R1
    end
  end

  // ************************************************************
  // register slave
  // ************************************************************
  logic [2:0] divField;
  logic [2:0] selField;
  logic divideApplied;
  logic wbWrite;
  logic wbRead;
  scsd_state_t state;

  // write lands on the edge where the master sees ack
  assign wbWrite = wbReq.cyc && wbReq.stb && wbReq.we && wbAck;
  assign wbRead = wbReq.cyc && wbReq.stb && !wbReq.we && !wbAck;

  // one wait state, ack drops the cycle after it is given
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= wbReq.cyc && wbReq.stb && !wbAck;
    end
  end

  // read data captured with ack; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wbDatOut <= '0;
    end else if (wbRead) begin
      wbDatOut <= '0;
      if (wbReq.adr == SCSD_ADDR_CLOCK_SELECT) begin
        wbDatOut[SCSD_APPLIED_BIT] <= divideApplied; // R8
        wbDatOut[SCSD_DIV_MSB:SCSD_DIV_LSB] <= divField;
        wbDatOut[SCSD_SEL_MSB:SCSD_SEL_LSB] <= selField;
      end else if (wbReq.adr == SCSD_ADDR_STATUS) begin
        wbDatOut[SCSD_ST_VALID_BIT] <= extOscValidFlag;
        wbDatOut[SCSD_ST_SWITCH_BIT] <= (state == SCSD_WAIT_NEW);
      end
    end else begin
      wbDatOut <= '0;
    end
  end

  // divide and select fields; reserved select codes leave source as is
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divField <= SCSD_DIV_RESET;
      selField <= SCSD_SEL_RESET;
    end else if (wbWrite && wbReq.sel[0] && wbReq.adr == SCSD_ADDR_CLOCK_SELECT) begin
      // bit 3 is not stored: it reads back zero whatever is written
      divField <= wbReq.dat[SCSD_DIV_MSB:SCSD_DIV_LSB]; // R6
      if (wbReq.dat[SCSD_SEL_MSB:SCSD_SEL_LSB] <= SCSD_SRC_LPOSC) begin
        selField <= wbReq.dat[SCSD_SEL_MSB:SCSD_SEL_LSB]; // R11
      end
    end
  end

  // ************************************************************
  // divider and switchover
  // ************************************************************
  logic [2:0] activeSel;
  logic [2:0] appliedDiv;
  logic [6:0] cnt;
  logic srcRise;
  logic srcFall;
  logic newRise;
  scsd_state_t next_state;
  logic [2:0] next_activeSel;
  logic [2:0] next_appliedDiv;
  logic [6:0] next_cnt;
  logic next_coreClock;

  assign srcRise = srcSync[activeSel] && !srcPrev[activeSel];
  assign srcFall = !srcSync[activeSel] && srcPrev[activeSel];
  assign newRise = srcSync[selField] && !srcPrev[selField];

  // changes happen only at a period boundary so no phase is cut short
  always_comb begin
    next_state = state;
    next_activeSel = activeSel;
    next_appliedDiv = appliedDiv;
    next_cnt = cnt;
    next_coreClock = coreClock;
    unique case (state)
      SCSD_RUN: begin
        if (srcRise) begin
          if (cnt == lastCount(appliedDiv)) begin // R5
            if (selField != activeSel) begin
              // hold low: stretching low is safe, cutting it is not
              next_state = SCSD_WAIT_NEW; // R10
              next_coreClock = 1'b0; // R14
            end else begin
              next_appliedDiv = divField; // R7
              next_cnt = '0;
              next_coreClock = 1'b1; // R14
            end
          end else begin
            next_cnt = 7'(cnt + 7'h01);
            next_coreClock = (7'(cnt + 7'h01) < halfCount(appliedDiv)); // R6
          end
        end else if (srcFall && appliedDiv == 3'h0) begin
          next_coreClock = 1'b0; // R5
        end
      end
      SCSD_WAIT_NEW: begin
        if (newRise) begin
          next_state = SCSD_RUN; // R10
          next_activeSel = selField;
          next_appliedDiv = divField;
          next_cnt = '0;
          next_coreClock = 1'b1; // R14
        end
      end
    endcase
  end

  // divider state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= SCSD_RUN;
      activeSel <= SCSD_SEL_RESET;
      appliedDiv <= SCSD_DIV_RESET;
      // start at the period end so the first source edge opens a full high phase
      cnt <= lastCount(SCSD_DIV_RESET);
      coreClock <= 1'b0;
    end else begin
      state <= next_state;
      activeSel <= next_activeSel;
      appliedDiv <= next_appliedDiv;
      cnt <= next_cnt;
      coreClock <= next_coreClock;
    end
  end

  // applied flag tracks the next values, so a write drops it at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divideApplied <= 1'b1;
    end else if (wbWrite && wbReq.sel[0] && wbReq.adr == SCSD_ADDR_CLOCK_SELECT) begin
      divideApplied <= (wbReq.dat[SCSD_DIV_MSB:SCSD_DIV_LSB] == next_appliedDiv); // R8
    end else begin
      divideApplied <= (divField == next_appliedDiv); // R8
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  logic [7:0] pendRises;

  // source edges seen while a divide change waits
  always_ff @(posedge clk) begin
    if (sys_rst || divField == appliedDiv || state != SCSD_RUN) begin
      pendRises <= '0;
    end else if (srcRise && pendRises != 8'hFF) begin
      pendRises <= 8'(pendRises + 8'h01);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_cmos_valid_zero: assert property (extOscCmosMode |=> !extOscValidFlag) // R1
    else $error("valid flag high in cmos clock mode");
  a_count_in_ratio: assert property (state == SCSD_RUN |-> cnt <= lastCount(appliedDiv)) // R5
    else $error("divider count beyond ratio");
  a_high_phase_len: assert property ( // R6
    $fell(coreClock) && $stable(appliedDiv) && appliedDiv != 3'h0 && $past(state) == SCSD_RUN
      |-> cnt == halfCount(appliedDiv))
    else $error("core clock high phase wrong length");
  // never more than one full slowest period of source edges
  a_divide_latency: assert property (pendRises <= 8'(SCSD_MAX_RATIO)) // R7
    else $error("divide change took over 128 source cycles");
  a_applied_drop: assert property ( // R8
    wbWrite && wbReq.sel[0] && wbReq.adr == SCSD_ADDR_CLOCK_SELECT
      && wbReq.dat[SCSD_DIV_MSB:SCSD_DIV_LSB] != next_appliedDiv |=> !divideApplied)
    else $error("applied flag high with divide pending");
  a_switch_done: assert property ( // R10
    state == SCSD_WAIT_NEW && newRise |=> activeSel == $past(selField) && coreClock)
    else $error("switchover did not complete on new source edge");
  a_select_legal: assert property (selField <= SCSD_SRC_LPOSC) // R11
    else $error("reserved source code accepted");
  a_rise_on_edge: assert property ($rose(coreClock) |-> $past(srcRise || newRise)) // R14
    else $error("core clock rose without a source edge");

  c_divide_change: cover property (divideApplied ##1 !divideApplied ##[1:300] divideApplied);
  c_source_switch: cover property (state == SCSD_WAIT_NEW ##1 state == SCSD_RUN);
  c_divide_by_one: cover property (appliedDiv == 3'h0 && $rose(coreClock));

  // a source switch holds the core clock low until the new edge arrives
  a_switch_held_low: assert property (state == SCSD_WAIT_NEW |-> !coreClock) // R14
    else $error("core clock high during source switchover");

  // the period-end edge is where a written ratio takes over and is reported
  a_reload_applied: assert property ( // R7
    state == SCSD_RUN && srcRise && cnt == lastCount(appliedDiv) && selField == activeSel
      && !wbWrite |=> appliedDiv == $past(divField) && divideApplied)
    else $error("divide setting not applied at period end");

  // outside cmos mode the flag is the synchronised detector, one flop later
  a_valid_follows: assert property ( // R1
    !extOscCmosMode |=> extOscValidFlag == $past(detSync))
    else $error("valid flag does not follow the detector");

  // reserved source codes are dropped, never stored
  a_reserved_kept: assert property ( // R11
    wbWrite && wbReq.sel[0] && wbReq.adr == SCSD_ADDR_CLOCK_SELECT
      && wbReq.dat[SCSD_SEL_MSB:SCSD_SEL_LSB] > SCSD_SRC_LPOSC |=> $stable(selField))
    else $error("reserved source code changed the select field");

  // divide by one: the core clock drops with the source
  a_div1_follows: assert property ( // R5
    state == SCSD_RUN && appliedDiv == 3'h0 && srcFall |=> !coreClock)
    else $error("core clock high after source fell at divide by one");

  // one-cycle answer; a held ack would land a write twice
  a_ack_single: assert property (wbAck |=> !wbAck) // R8
    else $error("bus acknowledge held for two cycles");

  // read data only stands beside ack, so a stale flag cannot be picked up
  a_idle_data_zero: assert property (!wbAck |-> wbDatOut == '0) // R8
    else $error("read data present without acknowledge");

  // ************************************************************
  // further cover points
  // ************************************************************
  c_reserved_code: cover property (
    wbWrite && wbReq.dat[SCSD_SEL_MSB:SCSD_SEL_LSB] > SCSD_SRC_LPOSC);
  // detector high while cmos mode masks it
  c_cmos_masked: cover property (extOscCmosMode && detSync);

endmodule

/* scsd_pkg.sv */
// constants and carrier types for the system clock select and divider
// How it works
// R1 - cmos clock mode forces oscillator valid low
// R2 - software feeds cmos clock into pin two
// R3 - capacitor mode starts like resistor-capacitor mode
// R4 - software polls valid before selecting external oscillator
// R5 - divide ratios are powers of two, 1..128
// R6 - divider codes 000..111 give 1 to 128
// R7 - new ratio applied within 128 source cycles
// R8 - applied flag low until new divide applied
// R9 - software sets divide by 1 before sleep
// R10 - source switch completes after one slow period
// R11 - select codes 000..100 pick five sources
// R12 - software writes reset value to bit 3
// R13 - software bypasses flash one-shot above 10 MHz
// R14 - no shortened core clock phase on changes
package scsd_pkg;

  // ************************************************************
  // register map and field layout
  // ************************************************************
  localparam logic [7:0] SCSD_ADDR_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] SCSD_ADDR_STATUS = 8'h04;
  localparam int SCSD_APPLIED_BIT = 7;
  localparam int SCSD_DIV_MSB = 6;
  localparam int SCSD_DIV_LSB = 4;
  localparam int SCSD_SEL_MSB = 2;
  localparam int SCSD_SEL_LSB = 0;
  localparam int SCSD_ST_VALID_BIT = 0;
  localparam int SCSD_ST_SWITCH_BIT = 1;
  localparam logic [2:0] SCSD_DIV_RESET = 3'h3;
  localparam logic [2:0] SCSD_SEL_RESET = 3'h0;

  // ************************************************************
  // source codes and divider limits
  // ************************************************************
  localparam logic [2:0] SCSD_SRC_HFOSC = 3'h0;
  localparam logic [2:0] SCSD_SRC_EXTOSC = 3'h1;
  localparam logic [2:0] SCSD_SRC_LPDIV8 = 3'h2;
  localparam logic [2:0] SCSD_SRC_RTC = 3'h3;
  localparam logic [2:0] SCSD_SRC_LPOSC = 3'h4;
  localparam int SCSD_NUM_SRC = 5;
  localparam int SCSD_MAX_RATIO = 128;
  localparam int SCSD_CLK_MHZ = 10;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } scsd_wb_req_t;

  typedef enum {SCSD_RUN, SCSD_WAIT_NEW} scsd_state_t;

endpackage

/* system_clock_select_divider_tb.sv */
// self-checking bench for the clock select and divider block
`timescale 1ns/10ps
module system_clock_select_divider_tb
  import scsd_pkg::*;
;
  // ************************************************************
  // stimulus signals and score
  // ************************************************************
  logic clk;
  logic sys_rst;
  scsd_wb_req_t wbReq;
  logic [31:0] wbDatOut;
  logic wbAck;
  logic [SCSD_NUM_SRC-1:0] srcClockIn;
  logic extOscCmosMode;
  logic extOscDetectRaw;
  logic coreClock;
  logic extOscValidFlag;
  int miscompares;
  int cmp_count;
  int seed;
  logic [31:0] rdData;
  logic [63:0] expQ[$];
  int srcPer[SCSD_NUM_SRC] = '{16, 20, 24, 40, 28};

  scsd_clock_select dut_u (.clk(clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .srcClockIn(srcClockIn), .extOscCmosMode(extOscCmosMode),
    .extOscDetectRaw(extOscDetectRaw), .coreClock(coreClock), .extOscValidFlag(extOscValidFlag));

  // 10 MHz system clock; sources toggle on falling clk edges so sampling never races
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // every source stays far below 10 MHz, so the flash one-shot stays in use
  initial srcClockIn = '0;
  always #800 srcClockIn[0] = ~srcClockIn[0];
  // source one stands for the external oscillator, run with cmos mode off so its valid flag can be polled
  always #1000 srcClockIn[1] = ~srcClockIn[1];
  always #1200 srcClockIn[2] = ~srcClockIn[2];
  always #2000 srcClockIn[3] = ~srcClockIn[3];
  always #1400 srcClockIn[4] = ~srcClockIn[4];

  // ************************************************************
  // compare and closing tasks
  // ************************************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmpData(input logic [31:0] exp, input logic [31:0] got, input logic [31:0] m);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      miscompares++;
      $display("FAIL t=%0t data got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpInt(input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      miscompares++;
      $display("FAIL t=%0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("FAIL t=%0t timeout %s", $time, what);
    print_verdict();
  endtask

  // ************************************************************
  // wishbone master: expected note queued, ack sampled on the rising edge
  // ************************************************************
  task automatic wbCycle(input logic [7:0] adr, input logic we, input logic [7:0] d,
                         input logic [31:0] exp, input logic [31:0] m);
    int n;
    expQ.push_back({m, exp});
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: adr,
               dat: {24'($random(seed)), d}};
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) hang("ack");
    end while (wbAck !== 1'b1);
    // read data is taken at the very edge that shows ack, then released
    rdData = wbDatOut;
    wbReq <= '0;
  endtask

  // monitor takes the oldest note whenever the slave answers
  always @(posedge clk) begin
    logic [63:0] e;
    if (wbAck === 1'b1) begin
      if (expQ.size() == 0) hang("queue");
      e = expQ.pop_front();
      if (e[63:32] !== 32'h0) cmpData(e[31:0], wbDatOut, e[63:32]);
    end
  end

  // cycles until coreClock shows the given level
  task automatic waitLevel(input logic v, output int cnt);
    cnt = 0;
    while (coreClock !== v) begin
      @(posedge clk);
      cnt++;
      if (cnt > 9000) hang("core clock");
    end
  endtask

  task automatic measure(output int hi, output int per);
    int lo;
    int d;
    waitLevel(1'b0, d);
    waitLevel(1'b1, d);
    @(posedge clk);
    waitLevel(1'b0, hi);
    waitLevel(1'b1, lo);
    hi = hi + 1;
    per = hi + lo;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int hi;
    int per;
    int n;
    logic [2:0] c;
    miscompares = 0;
    cmp_count = 0;
    seed = 32'hf17d;
    sys_rst = 1'b1;
    wbReq = '0;
    extOscCmosMode = 1'b0;
    extOscDetectRaw = 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    wbCycle(SCSD_ADDR_CLOCK_SELECT, 1'b0, 8'h00, 32'hB0, 32'hFFFFFFFF);
    // unmapped place: acked, reads zero, write leaves the register alone
    wbCycle(8'h08, 1'b1, 8'h5A, 32'h0, 32'h0);
    wbCycle(8'h08, 1'b0, 8'h00, 32'h0, 32'hFFFFFFFF);
    wbCycle(SCSD_ADDR_CLOCK_SELECT, 1'b0, 8'h00, 32'hB0, 32'hFFFFFFFF);
    // every divider code: flag drops, then rises within the bound, then ratio holds
    for (int i = 0; i < 8; i++) begin
      c = 3'(i + 1);
      // bit 3 always written as its reset value of zero
      wbCycle(SCSD_ADDR_CLOCK_SELECT, 1'b1, {1'b0, c, 4'h0}, 32'h0, 32'h0);
      // first change may meet a period end at once; later ones land early in a period
      wbCycle(SCSD_ADDR_CLOCK_SELECT, 1'b0, 8'h00, {25'h0, c, 4'h0},
              (i == 0) ? 32'h7F : 32'hFF);
      n = 0;
      do begin
        wbCycle(SCSD_ADDR_CLOCK_SELECT, 1'b0, 8'h00, 32'h0, 32'h0);
        n++;
        if (n > 1200) hang("divide applied");
      end while (rdData[SCSD_APPLIED_BIT] !== 1'b1);
      measure(hi, per);
      cmpInt(srcPer[0] << c, per);
      cmpInt((srcPer[0] / 2) << c, hi);
    end
    // source codes 1 to 4, each checked at divide by one after the switchover
    for (int s = 1; s < SCSD_NUM_SRC; s++) begin
      if (s == int'(SCSD_SRC_EXTOSC)) begin
        // external oscillator is only selected once its valid flag reads one
        extOscDetectRaw <= 1'b1;
        n = 0;
        do begin
          wbCycle(SCSD_ADDR_STATUS, 1'b0, 8'h00, 32'h0, 32'h0);
          n++;
          if (n > 50) hang("oscillator valid");
        end while (rdData[SCSD_ST_VALID_BIT] !== 1'b1);
      end
      wbCycle(SCSD_ADDR_CLOCK_SELECT, 1'b1, 8'(s), 32'h0, 32'h0);
      wbCycle(SCSD_ADDR_CLOCK_SELECT, 1'b0, 8'h00, 32'(s), 32'hFFFFFF7F);
      measure(hi, per);
      measure(hi, per);
      cmpInt(srcPer[s], per);
      cmpInt(srcPer[s] / 2, hi);
    end
    for (int r = 5; r < 8; r++) begin
      wbCycle(SCSD_ADDR_CLOCK_SELECT, 1'b1, 8'(r), 32'h0, 32'h0);
      wbCycle(SCSD_ADDR_CLOCK_SELECT, 1'b0, 8'h00, 32'h4, 32'h7);
    end
    // divide by one and applied, as software leaves it before sleep
    wbCycle(SCSD_ADDR_CLOCK_SELECT, 1'b0, 8'h00, 32'h84, 32'hFF);
    // detector passes through normally, stays low in cmos mode whatever it does
    @(posedge clk);
    extOscDetectRaw <= 1'b1;
    repeat (6) @(posedge clk);
    cmpData(32'h1, {31'h0, extOscValidFlag}, 32'h1);
    wbCycle(SCSD_ADDR_STATUS, 1'b0, 8'h00, 32'h1, 32'h1);
    @(posedge clk);
    extOscCmosMode <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 20; k++) begin
      extOscDetectRaw <= 1'($random(seed));
      @(negedge clk);
      cmpData(32'h0, {31'h0, extOscValidFlag}, 32'h1);
      @(posedge clk);
    end
    wbCycle(SCSD_ADDR_STATUS, 1'b0, 8'h00, 32'h0, 32'h1);
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule
